// ==== common/slice_exec_pkg.sv ====
// Purpose: constants for the skip, branch, move and load/store execution slice
// Assumes: AHB-Lite register window, byte addresses, word aligned registers
// Notes:   flag bit positions follow the flag_register layout
package slice_exec_pkg;
  // register window byte offsets
  localparam logic [11:0] OPCODE_OFS  = 12'h000;
  localparam logic [11:0] OPERAND_OFS = 12'h004;
  localparam logic [11:0] FOLLOW_OFS  = 12'h008;
  localparam logic [11:0] PC_OFS      = 12'h00c;
  localparam logic [11:0] FLAGS_OFS   = 12'h010;
  localparam logic [11:0] STATUS_OFS  = 12'h014;
  localparam logic [11:0] GPR_BASE    = 12'h100;
  localparam logic [11:0] IO_BASE     = 12'h200;
  localparam logic [11:0] DMEM_BASE   = 12'h400;
  // reset values
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] OPCODE_RESET = 16'h0000;
  // flag_register bit positions
  localparam logic [2:0] FLAG_C = 3'd0;
  localparam logic [2:0] FLAG_Z = 3'd1;
  localparam logic [2:0] FLAG_N = 3'd2;
  localparam logic [2:0] FLAG_V = 3'd3;
  localparam logic [2:0] FLAG_S = 3'd4;
  localparam logic [2:0] FLAG_H = 3'd5;
  localparam logic [2:0] FLAG_T = 3'd6;
  localparam logic [2:0] FLAG_I = 3'd7;
  // status register bit positions
  localparam int STAT_BUSY   = 0;
  localparam int STAT_CYC_LO = 1;
  localparam int STAT_TAKEN  = 3;
  localparam int STAT_BAD    = 4;
  // pointer register pairs (low byte index)
  localparam logic [4:0] PTR_X = 5'd26;
  localparam logic [4:0] PTR_Y = 5'd28;
  localparam logic [4:0] PTR_Z = 5'd30;
  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'd1;
  localparam logic [1:0] CYC_TWO = 2'd2;
  // program counter steps
  localparam logic [15:0] STEP_ONE   = 16'h0001;
  localparam logic [15:0] STEP_TWO   = 16'h0002;
  localparam logic [15:0] STEP_THREE = 16'h0003;
  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum {st_idle, st_exec, st_finish} exec_state_e;
  typedef enum {k_none, k_skip_reg, k_skip_io, k_branch, k_move, k_const, k_load, k_store} kind_e;
endpackage : slice_exec_pkg

// ==== hdl/slice_exec.sv ====
// Purpose: execution of skips, flag branches, moves, constant and memory loads, pointer stores
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   writing the opcode register starts one instruction; poll status busy
//
// Behaviour
// - register bit one skips next instruction, pc plus 2 or 3, 1/2 clocks
// - io bit zero skips next instruction, otherwise continue, 1/2 clocks
// - io bit one skips next instruction, otherwise continue, 1/2 clocks
// - branch on flag one loads pc plus offset plus one
// - branch on flag zero takes offset, 1/2 clocks
// - carry-zero branch taken only with carry clear
// - unsigned not-lower equals carry-zero, lower equals carry-one
// - signed not-less taken when negative xor overflow is zero
// - signed less taken when negative xor overflow is one
// - half-carry branches follow half-carry flag, 1/2 clocks
// - transfer-bit branches follow transfer flag, pc plus offset plus one
// - overflow branches follow overflow flag
// - interrupt branches follow global enable; no branch alters flags
// - register copy and constant load take one clock, flags unchanged
// - post-increment load reads at pointer then increments, two clocks
// - pre-decrement load decrements pointer then reads, two clocks
// - displacement load reads pointer plus offset, pointer unchanged, two clocks
// - absolute load reads address from second word, two clocks, no flags
// - post-increment store writes at pointer then increments, two clocks
// - pre-decrement store decrements pointer then writes, two clocks
// - register bit zero skips next instruction, 1/2 clocks
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
module slice_exec (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  import slice_exec_pkg::*;

  logic [7:0] gpr [32];
  logic [7:0] io_reg [32];
  logic [7:0] dmem [256];

  exec_state_e state, next_state;
  logic [15:0] opcode, next_opcode;
  logic [15:0] operand, next_operand;
  logic [15:0] follow, next_follow;
  logic [15:0] pc, next_pc;
  logic [7:0]  flags, next_flags;
  logic [15:0] mem_addr, next_mem_addr;
  logic        mem_store, next_mem_store;
  logic [4:0]  mem_reg, next_mem_reg;
  logic [1:0]  last_cycles, next_last_cycles;
  logic        last_taken, next_last_taken;
  logic        last_bad, next_last_bad;
  logic        dp_valid, next_dp_valid;
  logic        dp_write, next_dp_write;
  logic [11:0] dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;

  // decode results of the current opcode
  kind_e       ex_kind;
  logic        ex_taken;
  logic        ex_bad;
  logic [1:0]  ex_cycles;
  logic [15:0] ex_pc;
  logic        ex_rf_we;
  logic [7:0]  ex_rf_wd;
  logic        ex_ptr_we;
  logic [4:0]  ex_ptr_idx;
  logic [15:0] ex_ptr_wd;
  logic [15:0] ex_addr;

  // write ports into the storage arrays; pointer steps write gpr through ex_ptr_we
  logic        rf_we;
  logic [4:0]  rf_wa;
  logic [7:0]  rf_wd;
  logic        io_we;
  logic        dm_we;
  logic [7:0]  dm_wa;
  logic [7:0]  dm_wd;
  logic        bus_wr;

  function automatic logic [15:0] ptr_of(input logic [4:0] idx);
    ptr_of = {gpr[idx + 5'd1], gpr[idx]};
  endfunction : ptr_of

  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[15:10] == 6'b100100 && w[3:0] == 4'h0) || (w[15:9] == 7'b1001010 && w[3:2] == 2'b11);
  endfunction : two_word

  function automatic logic [31:0] read_reg(input logic [11:0] a);
    if (a == OPCODE_OFS) begin
      read_reg = {16'h0000, opcode};
    end else if (a == OPERAND_OFS) begin
      read_reg = {16'h0000, operand};
    end else if (a == FOLLOW_OFS) begin
      read_reg = {16'h0000, follow};
    end else if (a == PC_OFS) begin
      read_reg = {16'h0000, pc};
    end else if (a == FLAGS_OFS) begin
      read_reg = {24'h000000, flags};
    end else if (a == STATUS_OFS) begin
      read_reg = {27'h0000000, last_bad, last_taken, last_cycles, state != st_idle};
    end else if (a[11:7] == GPR_BASE[11:7]) begin
      read_reg = {24'h000000, gpr[a[6:2]]};
    end else if (a[11:7] == IO_BASE[11:7]) begin
      read_reg = {24'h000000, io_reg[a[6:2]]};
    end else if (a[11:10] == DMEM_BASE[11:10]) begin
      read_reg = {24'h000000, dmem[a[9:2]]};
    end else begin
      read_reg = 32'h00000000;
    end
  endfunction : read_reg

  // instruction decode and first-cycle effects
  always_comb begin
    logic        cond;
    logic [4:0]  pidx;
    logic [15:0] pval;
    logic [15:0] rel;
    logic [15:0] disp;
    cond       = 1'b0;
    pidx       = PTR_X;
    pval       = 16'h0000;
    rel        = {{9{opcode[9]}}, opcode[9:3]};
    disp       = {10'h000, opcode[13], opcode[11:10], opcode[2:0]};
    ex_kind    = k_none;
    ex_taken   = 1'b0;
    ex_bad     = 1'b0;
    ex_cycles  = CYC_ONE;
    ex_pc      = pc + STEP_ONE;
    ex_rf_we   = 1'b0;
    ex_rf_wd   = 8'h00;
    ex_ptr_we  = 1'b0;
    ex_ptr_idx = PTR_X;
    ex_ptr_wd  = 16'h0000;
    ex_addr    = 16'h0000;
    if (opcode[15:11] == 5'b11110) begin
      ex_kind = k_branch;
      // signed test uses negative xor overflow directly, not a stored copy
      cond = (opcode[2:0] == FLAG_S) ? (flags[FLAG_N] ^ flags[FLAG_V]) : flags[opcode[2:0]];
      ex_taken = opcode[10] ? !cond : cond;
      if (ex_taken) begin
        ex_pc     = pc + rel + STEP_ONE;
        ex_cycles = CYC_TWO;
      end
    end else if (opcode[15:10] == 6'b111111) begin
      // bit 9 picks the one or zero form; the 111110 space is another slice's bit transfer
      ex_kind  = k_skip_reg;
      ex_bad   = opcode[3];
      ex_taken = (gpr[opcode[8:4]][opcode[2:0]] == opcode[9]) && !opcode[3];
    end else if (opcode[15:8] == 8'h99 || opcode[15:8] == 8'h9b) begin
      ex_kind  = k_skip_io;
      ex_taken = io_reg[opcode[7:3]][opcode[2:0]] == opcode[9];
    end else if (opcode[15:10] == 6'b001011) begin
      ex_kind  = k_move;
      ex_rf_we = 1'b1;
      ex_rf_wd = gpr[{opcode[9], opcode[3:0]}];
    end else if (opcode[15:12] == 4'he) begin
      ex_kind  = k_const;
      ex_rf_we = 1'b1;
      ex_rf_wd = {opcode[11:8], opcode[3:0]};
    end else if (opcode[15:10] == 6'b100100) begin
      ex_kind   = opcode[9] ? k_store : k_load;
      ex_cycles = CYC_TWO;
      pidx = (opcode[3:2] == 2'b11) ? PTR_X : ((opcode[3] == 1'b1) ? PTR_Y : PTR_Z);
      pval = ptr_of(pidx);
      ex_ptr_idx = pidx;
      if (opcode[3:0] == 4'h0) begin
        ex_addr = operand;
        ex_pc   = pc + STEP_TWO;
        ex_bad  = opcode[9];
      end else if (opcode[3:0] == 4'hc) begin
        ex_addr = pval;
      end else if (opcode[3:0] == 4'hd || opcode[3:0] == 4'h9 || opcode[3:0] == 4'h1) begin
        ex_addr   = pval;
        ex_ptr_we = 1'b1;
        ex_ptr_wd = pval + STEP_ONE;
      end else if (opcode[3:0] == 4'he || opcode[3:0] == 4'ha || opcode[3:0] == 4'h2) begin
        ex_ptr_we = 1'b1;
        ex_ptr_wd = pval - STEP_ONE;
        ex_addr   = ex_ptr_wd;
      end else begin
        ex_bad = 1'b1;
      end
    end else if (opcode[15:14] == 2'b10 && opcode[12] == 1'b0) begin
      ex_kind   = opcode[9] ? k_store : k_load;
      ex_cycles = CYC_TWO;
      ex_addr   = ptr_of(opcode[3] ? PTR_Y : PTR_Z) + disp;
    end else begin
      ex_bad = 1'b1;
    end
    if (ex_kind == k_skip_reg || ex_kind == k_skip_io) begin
      if (ex_taken) begin
        ex_pc     = pc + (two_word(follow) ? STEP_THREE : STEP_TWO);
        ex_cycles = CYC_TWO;
      end
    end
    if (ex_bad) begin
      ex_kind   = k_none;
      ex_taken  = 1'b0;
      ex_rf_we  = 1'b0;
      ex_ptr_we = 1'b0;
      ex_cycles = CYC_ONE;
      ex_pc     = pc + STEP_ONE;
    end
  end

  // sequencing, bus registers and read data
  always_comb begin
    bus_wr           = dp_valid && dp_write && state == st_idle;
    next_state       = state;
    next_opcode      = opcode;
    next_operand     = operand;
    next_follow      = follow;
    next_pc          = pc;
    next_flags       = flags; // flags only change by a bus write, never by execution
    next_mem_addr    = mem_addr;
    next_mem_store   = mem_store;
    next_mem_reg     = mem_reg;
    next_last_cycles = last_cycles;
    next_last_taken  = last_taken;
    next_last_bad    = last_bad;
    next_dp_valid    = hsel && hready && htrans == HTRANS_NONSEQ;
    next_dp_write    = hwrite;
    next_dp_addr     = haddr[11:0];
    next_hrdata      = (next_dp_valid && !hwrite && haddr[31:12] == 20'h00000) ? read_reg(haddr[11:0]) : 32'h0;
    rf_we = 1'b0;
    rf_wa = opcode[8:4];
    rf_wd = 8'h00;
    io_we = 1'b0;
    dm_we = 1'b0;
    dm_wa = mem_addr[7:0];
    dm_wd = gpr[mem_reg];
    case (state)
      st_idle: begin
        if (bus_wr) begin
          if (dp_addr == OPCODE_OFS) begin
            next_opcode = hwdata[15:0];
            next_state  = st_exec;
          end else if (dp_addr == OPERAND_OFS) begin
            next_operand = hwdata[15:0];
          end else if (dp_addr == FOLLOW_OFS) begin
            next_follow = hwdata[15:0];
          end else if (dp_addr == PC_OFS) begin
            next_pc = hwdata[15:0];
          end else if (dp_addr == FLAGS_OFS) begin
            next_flags = hwdata[7:0];
          end else if (dp_addr[11:7] == GPR_BASE[11:7]) begin
            rf_we = 1'b1;
            rf_wa = dp_addr[6:2];
            rf_wd = hwdata[7:0];
          end else if (dp_addr[11:7] == IO_BASE[11:7]) begin
            io_we = 1'b1;
          end else if (dp_addr[11:10] == DMEM_BASE[11:10]) begin
            dm_we = 1'b1;
            dm_wa = dp_addr[9:2];
            dm_wd = hwdata[7:0];
          end
        end
      end
      st_exec: begin
        next_pc          = ex_pc;
        next_last_cycles = ex_cycles;
        next_last_taken  = ex_taken;
        next_last_bad    = ex_bad;
        rf_we            = ex_rf_we;
        rf_wa            = (ex_kind == k_const) ? {1'b1, opcode[7:4]} : opcode[8:4];
        rf_wd            = ex_rf_wd;
        next_mem_addr    = ex_addr;
        next_mem_store   = ex_kind == k_store;
        next_mem_reg     = opcode[8:4];
        next_state       = (ex_cycles == CYC_TWO && (ex_kind == k_load || ex_kind == k_store)) ? st_finish
                         : ((ex_cycles == CYC_TWO) ? st_finish : st_idle);
      end
      st_finish: begin
        // memory access happens after any pointer step of the first cycle
        rf_we      = !mem_store && last_cycles == CYC_TWO && !last_taken
                     && opcode[15:14] != 2'b11;
        rf_wa      = mem_reg;
        rf_wd      = dmem[mem_addr[7:0]];
        dm_we      = mem_store && opcode[15:14] != 2'b11;
        next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state       <= st_idle;
      opcode      <= OPCODE_RESET;
      operand     <= 16'h0000;
      follow      <= 16'h0000;
      pc          <= PC_RESET;
      flags       <= FLAGS_RESET;
      mem_addr    <= 16'h0000;
      mem_store   <= 1'b0;
      mem_reg     <= 5'd0;
      last_cycles <= 2'd0;
      last_taken  <= 1'b0;
      last_bad    <= 1'b0;
      dp_valid    <= 1'b0;
      dp_write    <= 1'b0;
      dp_addr     <= 12'h000;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b0;
      hresp       <= HRESP_OKAY;
    end else begin
      state       <= next_state;
      opcode      <= next_opcode;
      operand     <= next_operand;
      follow      <= next_follow;
      pc          <= next_pc;
      flags       <= next_flags;
      mem_addr    <= next_mem_addr;
      mem_store   <= next_mem_store;
      mem_reg     <= next_mem_reg;
      last_cycles <= next_last_cycles;
      last_taken  <= next_last_taken;
      last_bad    <= next_last_bad;
      dp_valid    <= next_dp_valid;
      dp_write    <= next_dp_write;
      dp_addr     <= next_dp_addr;
      hrdata      <= next_hrdata;
      hreadyout   <= 1'b1;
      hresp       <= HRESP_OKAY;
    end
  end

  // storage arrays are not reset; software loads what a test needs
  always_ff @(posedge core_clk) begin
    if (state == st_exec && ex_ptr_we) begin
      gpr[ex_ptr_idx]         <= ex_ptr_wd[7:0];
      gpr[ex_ptr_idx + 5'd1]  <= ex_ptr_wd[15:8];
    end
    if (rf_we) begin
      gpr[rf_wa] <= rf_wd;
    end
    if (io_we) begin
      io_reg[dp_addr[6:2]] <= hwdata[7:0];
    end
    // only 256 bytes of data memory: higher address bits are ignored
    if (dm_we) begin
      dmem[dm_wa] <= dm_wd;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic [15:0] chk_rel;
  assign chk_rel = {{9{opcode[9]}}, opcode[9:3]};

  sequence s_two_cycle;
    state == st_exec ##1 state == st_finish ##1 state == st_idle;
  endsequence
  sequence s_one_cycle;
    state == st_exec ##1 state == st_idle;
  endsequence

  property p_skip_reg;
    (state == st_exec && opcode[15:9] == 7'b1111111 && !opcode[3] && gpr[opcode[8:4]][opcode[2:0]])
      |=> pc == $past(pc) + (two_word(follow) ? STEP_THREE : STEP_TWO) && state == st_finish;
  endproperty
  a_skip_reg: assert property (p_skip_reg) else $error("register bit skip wrong");

  property p_skip_reg_zero;
    (state == st_exec && opcode[15:9] == 7'b1111110 && !opcode[3] && gpr[opcode[8:4]][opcode[2:0]])
      |=> pc == $past(pc) + STEP_ONE && state == st_idle;
  endproperty
  a_skip_reg_zero: assert property (p_skip_reg_zero) else $error("clear-bit skip taken on one");

  property p_skip_io_zero;
    (state == st_exec && opcode[15:8] == 8'h99 && !io_reg[opcode[7:3]][opcode[2:0]])
      |=> pc - $past(pc) >= STEP_TWO ##1 state == st_idle;
  endproperty
  a_skip_io_zero: assert property (p_skip_io_zero) else $error("io zero skip missed");

  property p_skip_io_one;
    (state == st_exec && opcode[15:8] == 8'h9b && !io_reg[opcode[7:3]][opcode[2:0]])
      |=> pc == $past(pc) + STEP_ONE;
  endproperty
  a_skip_io_one: assert property (p_skip_io_one) else $error("io one skip taken on zero");

  property p_branch_taken;
    (opcode[15:11] == 5'b11110 && opcode[2:0] != FLAG_S && (flags[opcode[2:0]] != opcode[10])) ##0 s_two_cycle
      |-> pc == $past(pc, 2) + $past(chk_rel, 2) + STEP_ONE;
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("branch target wrong");

  property p_branch_not_taken;
    (state == st_exec && opcode[15:11] == 5'b11110 && opcode[2:0] != FLAG_S && flags[opcode[2:0]] == opcode[10])
      |-> s_one_cycle;
  endproperty
  a_branch_not_taken: assert property (p_branch_not_taken) else $error("untaken branch not one clock");

  property p_signed_less;
    (state == st_exec && opcode[15:10] == 6'b111100 && opcode[2:0] == FLAG_S)
      |=> (pc != $past(pc) + STEP_ONE) == $past(flags[FLAG_N] ^ flags[FLAG_V]);
  endproperty
  a_signed_less: assert property (p_signed_less) else $error("signed less branch wrong");

  property p_flags_kept;
    state == st_exec |=> $stable(flags);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("execution changed flags");

  property p_move_one_clock;
    (state == st_exec && opcode[15:10] == 6'b001011) |-> s_one_cycle ##0 gpr[$past(opcode[8:4])]
      == $past(gpr[{opcode[9], opcode[3:0]}]);
  endproperty
  a_move_one_clock: assert property (p_move_one_clock) else $error("register copy wrong");

  property p_post_inc;
    (state == st_exec && opcode[15:10] == 6'b100100 && opcode[3:0] == 4'hd)
      |-> s_two_cycle ##0 ptr_of(PTR_X) == $past(ptr_of(PTR_X), 2) + STEP_ONE;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("x post increment wrong");

  property p_pre_dec;
    (state == st_exec && opcode[15:10] == 6'b100100 && opcode[3:0] == 4'he)
      |=> mem_addr == $past(ptr_of(PTR_X)) - STEP_ONE && ptr_of(PTR_X) == mem_addr;
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("x pre decrement wrong");

  property p_absolute;
    (state == st_exec && opcode[15:9] == 7'b1001000 && opcode[3:0] == 4'h0)
      |=> mem_addr == $past(operand) && pc == $past(pc) + STEP_TWO;
  endproperty
  a_absolute: assert property (p_absolute) else $error("absolute load address wrong");
endmodule : slice_exec

// ==== test/test_slice_exec.sv ====
// Purpose: bench for the execution slice, driven over its bus window
// Assumes: zero wait states, one instruction in flight at a time
// Notes:   all expected values worked out here, never read back first
`timescale 1ns/1ns
module test_slice_exec;
  import slice_exec_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] q;
  logic [7:0]  f;
  logic        c;
  logic [7:0]  pat [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
  logic [15:0] ops [4] = '{16'hfc53, 16'hfe53, 16'h994b, 16'h9b4b};

  // single slave: its ready is the bus ready
  slice_exec dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  always #5 core_clk = ~core_clk;

  task automatic close_out;
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // a hang in any wait loop ends here
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  function automatic logic [11:0] ga(input int r);
    return GPR_BASE + 12'(r * 4);
  endfunction : ga

  function automatic logic [11:0] da(input int a);
    return DMEM_BASE + 12'(a * 4);
  endfunction : da

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // entered right after a rising edge; read data taken at the closing edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic ck(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : ck

  // start one instruction, wait for idle, compare its cycle count
  task automatic run(input logic [15:0] op, input logic [1:0] cyc);
    xfer(1'b1, OPCODE_OFS, {16'h0, op});
    do xfer(1'b0, STATUS_OFS, 32'h0); while (q[STAT_BUSY] !== 1'b0);
    chk({30'h0, q[STAT_CYC_LO +: 2]}, {30'h0, cyc});
  endtask : run

  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    ck(PC_OFS, {16'h0, PC_RESET});
    ck(FLAGS_OFS, {24'h0, FLAGS_RESET});
    ck(STATUS_OFS, 32'h0);
    xfer(1'b1, 12'h018, 32'hffffffff);
    ck(12'h018, 32'h0);
    ck(12'hffc, 32'h0);
    // patterns ff and aa make n xor v differ from the stored s bit
    for (int p = 0; p < 4; p++) begin
      f = pat[p];
      for (int s = 0; s < 8; s++) begin
        for (int z = 0; z < 2; z++) begin
          c = (s == 4) ? f[FLAG_N] ^ f[FLAG_V] : f[s];
          c = c ^ z[0];
          xfer(1'b1, FLAGS_OFS, {24'h0, f});
          xfer(1'b1, PC_OFS, 32'h0100);
          run({5'b11110, z[0], (z[0] ? 7'h40 : 7'h3f), 3'(s)}, c ? CYC_TWO : CYC_ONE);
          chk({31'h0, q[STAT_TAKEN]}, {31'h0, c});
          ck(PC_OFS, c ? (z[0] ? 32'h00c1 : 32'h0140) : 32'h0101);
          ck(FLAGS_OFS, {24'h0, f});
        end
      end
    end
    for (int k = 0; k < 4; k++) begin
      for (int v = 0; v < 4; v++) begin
        xfer(1'b1, k < 2 ? ga(5) : IO_BASE + 12'h024, v[0] ? 32'h08 : 32'hf7);
        xfer(1'b1, FOLLOW_OFS, v[1] ? 32'h9000 : 32'h0000);
        xfer(1'b1, PC_OFS, 32'h0100);
        c = (v[0] == k[0]);
        run(ops[k], c ? CYC_TWO : CYC_ONE);
        chk({31'h0, q[STAT_TAKEN]}, {31'h0, c});
        ck(PC_OFS, c ? (v[1] ? 32'h0103 : 32'h0102) : 32'h0101);
      end
    end
    xfer(1'b1, FLAGS_OFS, 32'h55);
    run(16'hea05, CYC_ONE);
    run(16'h2e30, CYC_ONE);
    run(16'he51a, CYC_ONE);
    ck(ga(3), 32'ha5);
    xfer(1'b1, da(255), 32'h3c);
    xfer(1'b1, ga(26), 32'hff);
    xfer(1'b1, ga(27), 32'hff);
    run(16'h904d, CYC_TWO);
    ck(ga(4), 32'h3c);
    ck(ga(26), 32'h00);
    ck(ga(27), 32'h00);
    run(16'h905e, CYC_TWO);
    ck(ga(5), 32'h3c);
    ck(ga(27), 32'hff);
    run(16'h930d, CYC_TWO);
    ck(da(255), 32'ha5);
    ck(ga(26), 32'h00);
    run(16'h931e, CYC_TWO);
    ck(da(255), 32'h5a);
    run(16'h908c, CYC_TWO);
    ck(ga(8), 32'h5a);
    ck(ga(26), 32'hff);
    xfer(1'b1, ga(28), 32'h10);
    xfer(1'b1, ga(29), 32'h00);
    xfer(1'b1, da(8'h4f), 32'h77);
    run(16'hac6f, CYC_TWO);
    ck(ga(6), 32'h77);
    ck(ga(28), 32'h10);
    xfer(1'b1, OPERAND_OFS, 32'h4f);
    run(16'h9070, CYC_TWO);
    ck(ga(7), 32'h77);
    xfer(1'b1, ga(30), 32'h21);
    xfer(1'b1, ga(31), 32'h00);
    run(16'h9301, CYC_TWO);
    ck(da(8'h21), 32'ha5);
    ck(ga(30), 32'h22);
    run(16'h9092, CYC_TWO);
    ck(ga(9), 32'ha5);
    ck(ga(30), 32'h21);
    ck(FLAGS_OFS, 32'h55);
    close_out();
  end
endmodule : test_slice_exec
